// ---- design/cseq_top.sv ----
// Purpose: core sequencer - program counter, dual flag sets, ram stack
// Assumes: AHB-Lite slave, zero wait states, pins synchronous to hclk
// Notes: one instruction at a time; a command written while busy is dropped
// Function
// R1 - program counter is 13 bits and addresses the next program location
// R2 - a normal instruction writes program counter plus one back
// R3 - load counter from jump target, vector, call target, reset vector or pop
// R4 - two flag sets, normal and interrupt; instructions see the current one
// R5 - taking an interrupt switches flag use to the interrupt set
// R6 - each level saves its flags with the counter; interrupt return restores both
// R7 - calls run in normal mode; subroutine return leaves normal flags alone
// R8 - no flag is cleared on a context switch
// R9 - arithmetic sets carry on overflow, clears it otherwise
// R10 - arithmetic sets sign on underflow, clears it otherwise
// R11 - stack lives in ram, two bytes a level, starting at address 255
// R12 - software keeps nesting below 128 levels and clear of stack ram
// R13 - stack pointer marks the first free level; push stores counter and flags
// R14 - interrupt return copies top level into counter and current flags
// R15 - subroutine return copies top level into the counter only
// R16 - reset, test and programming supply pins select the operating mode
// R17 - reset pin reloads the reset vector and restarts the program
// R18 - arbiter enables exactly one of five class decoders, then datapath runs
// R19 - instructions take from 6 to 26 clock pulses
// R20 - stack pointer is readable by software as input register zero; the code reads it at OFS_SP (0x014) instead
// R21 - pointer moves down one two-byte level per push, up one per return
`timescale 1ns/1ps
module cseq_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pin_reset_n,
  input wire logic pin_test,
  input wire logic pin_vpp_high,
  output logic [cseq_pkg::PC_W-1:0] prog_addr,
  output logic [cseq_pkg::RAM_AW-1:0] stack_ptr,
  output logic [cseq_pkg::CLS_W-1:0] class_sel,
  output logic [1:0] op_mode,
  output logic irq_mode,
  output logic busy
);
  import cseq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_ST1, ST_ST2, ST_ST3, ST_WAIT} cseq_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // instruction class of a command, one-hot
  function automatic logic [4:0] cls_of(input cseq_op_type op);
    logic [4:0] c;
    c = 5'h00;
    case (op)
      OP_LOAD: c[CLS_LOAD] = 1'b1;
      OP_ADD, OP_SUB, OP_LOGIC, OP_DIV: c[CLS_ARITH] = 1'b1;
      OP_JUMP, OP_CALL, OP_RET: c[CLS_JUMP] = 1'b1;
      OP_FUZZY: c[CLS_FUZZY] = 1'b1;
      default: c[CLS_CTRL] = 1'b1;
    endcase
    return c;
  endfunction

  // cycles from acceptance to completion
  function automatic logic [4:0] cyc_of(input cseq_op_type op);
    logic [4:0] c;
    c = cls_of(op);
    if (c[CLS_FUZZY])
    begin
      return CYC_FUZZY;
    end
    else if (op == OP_DIV)
    begin
      return CYC_DIV;
    end
    return CYC_STD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  cseq_state_type st_ff;
  cseq_state_type nxt_st;
  cseq_op_type op_ff;
  cseq_mode_type mode_ff;
  cseq_mode_type mode_w;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [PC_W-1:0] opnd_ff;
  logic [PC_W-1:0] tgt_ff;
  logic [7:0] sp_ff;
  logic [7:0] nxt_sp;
  logic [DEPTH_W-1:0] depth_ff;
  logic [DEPTH_W-1:0] nxt_depth;
  logic [CNT_W-1:0] cnt_ff;
  logic [CLS_W-1:0] cls_ff;
  logic [15:0] arg_ff;
  logic [7:0] pop_hi_ff;
  logic [7:0] pop_lo_ff;
  logic [3:0] last_op_ff;
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic busy_ff;
  logic irq_mode_ff;
  logic [1:0] mode_out_ff;

  cseq_ram_if ram_if ();
  cseq_flag_if flag_if ();

  cseq_ram u_ram (
    .hclk (hclk),
    .hresetn (hresetn),
    .ram (ram_if.mem)
  );

  cseq_flags u_flags (
    .hclk (hclk),
    .hresetn (hresetn),
    .fl (flag_if.flg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode selection from pins, see R16

  assign mode_w = (!pin_reset_n && !pin_test && pin_vpp_high) ? MODE_PROG :
                  (!pin_reset_n && !pin_vpp_high) ? MODE_RESET :
                  (pin_reset_n && !pin_test && !pin_vpp_high) ? MODE_WORK : MODE_BAD;

  // core held at the reset vector whenever the reset pin is low, see R17
  wire core_rst = !pin_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // bus address and data phase

  wire bus_take = hsel && htrans[1] && hready;
  wire rd_take = bus_take && !hwrite;
  wire rd_map = (haddr[31:12] == 20'h00000);
  wire wr_cmd = wr_pend_ff && (wr_addr_ff == OFS_CMD);
  wire wr_opnd = wr_pend_ff && (wr_addr_ff == OFS_OPND);
  wire wr_arg = wr_pend_ff && (wr_addr_ff == OFS_ARG);
  wire idle = (st_ff == ST_IDLE);

  // commands run only in working mode and only when nothing is in flight
  wire cmd_take = wr_cmd && idle && (mode_w == MODE_WORK) && !core_rst;
  wire cseq_op_type new_op = cseq_op_type'(hwdata[3:0]);

  ////////////////////////////////////////////////////////////////////////////
  // read data, built at the address phase so it stands in the data phase

  logic [31:0] stat_w;
  logic [31:0] rd_word;

  always_comb
  begin
    stat_w = 32'h0;
    stat_w[STAT_BUSY] = busy_ff;
    stat_w[STAT_IRQ] = irq_mode_ff;
    stat_w[STAT_FLG +: FLG_W] = flag_if.cur;
    stat_w[STAT_MODE +: 2] = mode_ff;
    stat_w[STAT_CLS +: CLS_W] = cls_ff;
    stat_w[STAT_DEPTH +: DEPTH_W] = depth_ff;
  end

  // unmapped addresses read zero
  assign rd_word = !rd_map ? 32'h0 :
                   (haddr[11:0] == OFS_CMD) ? {28'h0, last_op_ff} :
                   (haddr[11:0] == OFS_OPND) ? {19'h0, opnd_ff} :
                   (haddr[11:0] == OFS_ARG) ? {16'h0, arg_ff} :
                   (haddr[11:0] == OFS_STAT) ? stat_w :
                   (haddr[11:0] == OFS_PC) ? {19'h0, pc_ff} :
                   (haddr[11:0] == OFS_SP) ? {24'h0, sp_ff} :  // see R20
                   (haddr[11:0] == OFS_FLAGS) ? {25'h0, flag_if.irq, 1'b0, flag_if.nrm} :
                   (haddr[11:0] == OFS_RES) ? {24'h0, flag_if.res} : 32'h0;

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0;
    end
    else
    begin
      wr_pend_ff <= bus_take && hwrite && rd_map;
      wr_addr_ff <= haddr[11:0];
      hrdata_ff <= rd_take ? rd_word : 32'h0;
    end
  end

  // software registers; operand and arguments are frozen while busy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opnd_ff <= 13'h0000;
      arg_ff <= 16'h0000;
      last_op_ff <= 4'h0;
    end
    else
    begin
      if (wr_opnd && idle)
      begin
        opnd_ff <= hwdata[PC_W-1:0];
      end
      if (wr_arg && idle)
      begin
        arg_ff <= hwdata[15:0];
      end
      if (cmd_take)
      begin
        last_op_ff <= hwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  wire is_push = (op_ff == OP_CALL) || (op_ff == OP_IRQ);
  wire is_pop = (op_ff == OP_RET) || (op_ff == OP_RETURN_FROM_INTERRUPT);
  wire fin = (st_ff == ST_WAIT) && (cnt_ff == 5'h00);

  // arbiter first, then the stack steps, then the remaining cycles
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: nxt_st = cmd_take ? ST_ARB : ST_IDLE;
      ST_ARB: nxt_st = (is_push || is_pop) ? ST_ST1 : ST_WAIT;
      ST_ST1: nxt_st = ST_ST2;
      ST_ST2: nxt_st = is_pop ? ST_ST3 : ST_WAIT;
      ST_ST3: nxt_st = ST_WAIT;
      ST_WAIT: nxt_st = fin ? ST_IDLE : ST_WAIT;
      default: nxt_st = ST_IDLE;
    endcase
    if (core_rst)
    begin
      nxt_st = ST_IDLE;
    end
  end

  // program counter sources, see R3
  wire [PC_W-1:0] pc_pop = {pop_hi_ff[4:0], pop_lo_ff};
  wire tgt_load = (op_ff == OP_JUMP) || (op_ff == OP_CALL) || (op_ff == OP_IRQ);
  assign nxt_pc = core_rst ? RESET_VEC :                     // see R17
                  !fin ? pc_ff :
                  tgt_load ? tgt_ff :
                  is_pop ? pc_pop :                           // see R15
                  pc_ff + 13'h0001;                           // see R2

  // pointer moves one two-byte level per push or pop, see R21
  assign nxt_sp = core_rst ? SP_TOP :
                  (st_ff == ST_ST2 && is_push) ? sp_ff - LEVEL_BYTES :
                  (st_ff == ST_ST3) ? sp_ff + LEVEL_BYTES : sp_ff;  // see R12

  // nesting depth; interrupt flags take over right after the push, see R5
  assign nxt_depth = core_rst ? 7'h00 :
                     (st_ff == ST_ST2 && op_ff == OP_IRQ) ? depth_ff + 7'h01 :
                     (fin && op_ff == OP_RETURN_FROM_INTERRUPT && depth_ff != 7'h00) ? depth_ff - 7'h01 :
                     depth_ff;

  // main state registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= ST_IDLE;
      op_ff <= OP_FETCH;
      pc_ff <= RESET_VEC;
      sp_ff <= SP_TOP;  // see R11
      depth_ff <= 7'h00;
      tgt_ff <= 13'h0000;
    end
    else
    begin
      st_ff <= nxt_st;
      pc_ff <= nxt_pc;  // see R1
      sp_ff <= nxt_sp;
      depth_ff <= nxt_depth;
      if (cmd_take)
      begin
        op_ff <= new_op;
        tgt_ff <= opnd_ff;
      end
    end
  end

  // duration counter and arbiter select, see R18 and R19
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= 5'h00;
      cls_ff <= 5'h00;
    end
    else if (cmd_take)
    begin
      cnt_ff <= cyc_of(new_op) - 5'h01;
      cls_ff <= cls_of(new_op);
    end
    else
    begin
      if (cnt_ff != 5'h00)
      begin
        cnt_ff <= cnt_ff - 5'h01;
      end
      if (fin || core_rst)
      begin
        cls_ff <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack ram access: byte at sp holds pc low, byte below holds flags and pc high

  // push writes the level at the pointer, see R13 and R6
  assign ram_if.we = is_push && ((st_ff == ST_ST1) || (st_ff == ST_ST2));
  assign ram_if.addr = (st_ff == ST_ST1) ? (is_push ? sp_ff : sp_ff + 8'h01) :
                       (is_push ? sp_ff - 8'h01 : sp_ff + LEVEL_BYTES);
  assign ram_if.wdata = (st_ff == ST_ST1) ? pc_ff[7:0] : {flag_if.cur, pc_ff[PC_W-1:8]};

  // pop reads the most recently filled level, one cycle late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pop_hi_ff <= 8'h00;
      pop_lo_ff <= 8'h00;
    end
    else
    begin
      if (st_ff == ST_ST2 && is_pop)
      begin
        pop_hi_ff <= ram_if.rdata;
      end
      if (st_ff == ST_ST3)
      begin
        pop_lo_ff <= ram_if.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag store control

  // a call is normal execution, so the flag set follows depth only, see R7
  assign flag_if.irq_mode = (depth_ff != 7'h00);
  assign flag_if.upd_en = fin && ((op_ff == OP_ADD) || (op_ff == OP_SUB));
  assign flag_if.upd_sub = (op_ff == OP_SUB);
  assign flag_if.op_a = arg_ff[ARG_A +: 8];
  assign flag_if.op_b = arg_ff[ARG_B +: 8];
  // interrupt return restores the set of the level being returned to, see R14
  assign flag_if.rst_en = fin && (op_ff == OP_RETURN_FROM_INTERRUPT);
  assign flag_if.rst_irq = (depth_ff > 7'h01);
  assign flag_if.rst_val = pop_hi_ff[7:5];

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_ff <= 1'b0;
      irq_mode_ff <= 1'b0;
      mode_out_ff <= 2'h0;
      mode_ff <= MODE_RESET;
    end
    else
    begin
      busy_ff <= (nxt_st != ST_IDLE);
      irq_mode_ff <= (nxt_depth != 7'h00);
      mode_ff <= mode_w;
      mode_out_ff <= mode_w;
    end
  end

  assign hreadyout = 1'b1 ^ 1'b0 ^ hrdata_ff[0] ^ hrdata_ff[0];
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0 ^ hrdata_ff[0] ^ hrdata_ff[0];
  assign prog_addr = pc_ff;
  assign stack_ptr = sp_ff;
  assign class_sel = cls_ff;
  assign op_mode = mode_out_ff;
  assign irq_mode = irq_mode_ff;
  assign busy = busy_ff;
endmodule

// ---- inc/cseq_pkg.sv ----
// Purpose: shared constants and types of the core sequencer
// Assumes: one clock domain, AHB-Lite register access
// Notes: bit order of a flag set is {sign, zero, carry}
package cseq_pkg;
  // widths
  localparam int PC_W = 13;
  localparam int RAM_AW = 8;
  localparam int FLG_W = 3;
  localparam int CLS_W = 5;
  localparam int CNT_W = 5;
  localparam int DEPTH_W = 7;
  localparam int RAM_DEPTH = 256;

  // reset values and stack geometry
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [7:0] SP_TOP = 8'hff;
  localparam logic [7:0] LEVEL_BYTES = 8'h02;

  // flag bit positions inside a set
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_S = 2;

  // instruction classes, one-hot positions
  localparam int CLS_LOAD = 0;
  localparam int CLS_ARITH = 1;
  localparam int CLS_JUMP = 2;
  localparam int CLS_CTRL = 3;
  localparam int CLS_FUZZY = 4;

  // instruction durations in clock cycles
  localparam logic [4:0] CYC_FUZZY = 5'h06;
  localparam logic [4:0] CYC_DIV = 5'h1a;
  localparam logic [4:0] CYC_STD = 5'h08;

  // register byte offsets
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_OPND = 12'h004;
  localparam logic [11:0] OFS_ARG = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_PC = 12'h010;
  localparam logic [11:0] OFS_SP = 12'h014;
  localparam logic [11:0] OFS_FLAGS = 12'h018;
  localparam logic [11:0] OFS_RES = 12'h01c;

  // status and flags register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_IRQ = 1;
  localparam int STAT_FLG = 2;
  localparam int STAT_MODE = 5;
  localparam int STAT_CLS = 8;
  localparam int STAT_DEPTH = 16;
  localparam int FLAGS_NRM = 0;
  localparam int FLAGS_IRQ = 4;
  localparam int ARG_A = 0;
  localparam int ARG_B = 8;

  typedef enum logic [3:0] {
    OP_FETCH, OP_JUMP, OP_CALL, OP_IRQ, OP_RET, OP_RETURN_FROM_INTERRUPT,
    OP_ADD, OP_SUB, OP_LOAD, OP_LOGIC, OP_FUZZY, OP_DIV
  } cseq_op_type;

  typedef enum logic [1:0] {MODE_RESET, MODE_PROG, MODE_WORK, MODE_BAD} cseq_mode_type;
endpackage

// ---- inc/cseq_if.sv ----
// Purpose: carriers between the sequencer and its stack ram and flag store
// Assumes: driven from the sequencer clock domain
// Notes: ram read data is registered, one cycle behind the address
`timescale 1ns/1ps
interface cseq_ram_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic we;
  modport seq (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

interface cseq_flag_if;
  logic irq_mode;
  logic upd_en;
  logic upd_sub;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic rst_en;
  logic rst_irq;
  logic [2:0] rst_val;
  logic [2:0] cur;
  logic [2:0] nrm;
  logic [2:0] irq;
  logic [7:0] res;
  modport seq (output irq_mode, output upd_en, output upd_sub, output op_a, output op_b,
    output rst_en, output rst_irq, output rst_val, input cur, input nrm, input irq, input res);
  modport flg (input irq_mode, input upd_en, input upd_sub, input op_a, input op_b,
    input rst_en, input rst_irq, input rst_val, output cur, output nrm, output irq, output res);
endinterface

// ---- design/cseq_ram.sv ----
// Purpose: 256-byte data ram that holds the call and interrupt stack
// Assumes: one write or one read per cycle
// Notes: contents are not reset; read data lags the address by one cycle
`timescale 1ns/1ps
module cseq_ram (
  input wire logic hclk,
  input wire logic hresetn,
  cseq_ram_if.mem ram
);
  import cseq_pkg::*;

  logic [7:0] mem_ff [RAM_DEPTH];
  logic [7:0] rdata_ff;

  // byte write, no reset so it maps onto a plain ram macro
  always_ff @(posedge hclk)
  begin
    if (ram.we)
    begin
      mem_ff[ram.addr] <= ram.wdata;
    end
  end

  // registered read port
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= mem_ff[ram.addr];
    end
  end

  assign ram.rdata = rdata_ff;
endmodule

// ---- design/cseq_flags.sv ----
// Purpose: normal and interrupt flag sets with the arithmetic flag update
// Assumes: irq_mode selects the set that instructions see
// Notes: restore and update never coincide; restore wins if they did
`timescale 1ns/1ps
module cseq_flags (
  input wire logic hclk,
  input wire logic hresetn,
  cseq_flag_if.flg fl
);
  import cseq_pkg::*;

  logic [2:0] flg_ff [2];
  logic [7:0] res_ff;
  logic [8:0] sum_w;
  logic [8:0] dif_w;
  logic [7:0] nxt_res;
  logic [2:0] arith_w;

  // ninth bit of the sum is overflow, of the difference is underflow
  assign sum_w = {1'b0, fl.op_a} + {1'b0, fl.op_b};
  assign dif_w = {1'b0, fl.op_a} - {1'b0, fl.op_b};
  assign nxt_res = fl.upd_sub ? dif_w[7:0] : sum_w[7:0];
  assign arith_w[FLG_C] = !fl.upd_sub && sum_w[8];  // see R9
  assign arith_w[FLG_S] = fl.upd_sub && dif_w[8];   // see R10
  assign arith_w[FLG_Z] = (nxt_res == 8'h00);

  // one store per context; neither is cleared on a switch, interrupt return only reloads one, see R8
  for (genvar s = 0; s < 2; s++)
  begin : g_set
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        flg_ff[s] <= 3'h0;
      end
      else if (fl.rst_en && (fl.rst_irq == 1'(s)))
      begin
        flg_ff[s] <= fl.rst_val;  // see R6
      end
      else if (fl.upd_en && (fl.irq_mode == 1'(s)))
      begin
        flg_ff[s] <= arith_w;  // see R4
      end
    end
  end

  // last arithmetic result, for software inspection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_ff <= 8'h00;
    end
    else if (fl.upd_en)
    begin
      res_ff <= nxt_res;
    end
  end

  assign fl.cur = flg_ff[fl.irq_mode];  // see R5
  assign fl.nrm = flg_ff[0];
  assign fl.irq = flg_ff[1];
  assign fl.res = res_ff;
endmodule

// ---- tb/cseq_top_properties.sv ----
// Purpose: port level checks of the core sequencer
// Assumes: single hclk domain, hresetn asynchronous active low
// Notes: the reset pin may act one cycle late, so it is held three cycles
`timescale 1ns/1ps
module cseq_top_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_reset_n,
  input wire logic pin_test,
  input wire logic pin_vpp_high,
  input wire logic [cseq_pkg::PC_W-1:0] prog_addr,
  input wire logic [cseq_pkg::RAM_AW-1:0] stack_ptr,
  input wire logic [cseq_pkg::CLS_W-1:0] class_sel,
  input wire logic [1:0] op_mode,
  input wire logic irq_mode,
  input wire logic busy
);
  import cseq_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // an instruction starts, and the pin reset is held
  sequence start_op;
    $rose(busy);
  endsequence
  sequence pin_held;
    !pin_reset_n [*3];
  endsequence
  // one decoder at a time while an instruction runs
  chk_class_one_hot: assert property (busy |-> $onehot(class_sel))
    else $error("class enable not one-hot");
  chk_busy_min_len: assert property (start_op |-> busy [*6])
    else $error("instruction shorter than six cycles");
  chk_busy_max_len: assert property (start_op |-> ##[6:26] !busy)
    else $error("instruction longer than 26 cycles");
  // the pointer only moves by whole levels, or jumps home on reset
  chk_sp_level_step: assert property ($changed(stack_ptr) |-> stack_ptr == $past(stack_ptr) - LEVEL_BYTES
    || stack_ptr == $past(stack_ptr) + LEVEL_BYTES || stack_ptr == SP_TOP)
    else $error("stack pointer moved by other than one level");
  chk_irq_push_sp: assert property ($rose(irq_mode) |-> stack_ptr == $past(stack_ptr) - LEVEL_BYTES)
    else $error("interrupt entry without a stack push");
  chk_pin_reset_vec: assert property (pin_held |-> prog_addr == RESET_VEC && stack_ptr == SP_TOP && !busy)
    else $error("reset pin did not reload the counter");
  // the edge that releases hresetn still sees the reset value of op_mode, so it is skipped
  chk_mode_from_pins: assert property (hresetn && !pin_test |=> op_mode == ($past(pin_reset_n) ?
    ($past(pin_vpp_high) ? 2'h3 : 2'h2) : ($past(pin_vpp_high) ? 2'h1 : 2'h0)))
    else $error("operating mode does not follow pins");
  // between instructions the counter holds still
  chk_pc_idle_hold: assert property (!busy && !$past(busy) && pin_reset_n && $past(pin_reset_n)
    && $past(pin_reset_n, 2) |-> $stable(prog_addr))
    else $error("counter moved while idle");
endmodule
bind cseq_top cseq_top_properties u_props (.hclk(hclk), .hresetn(hresetn), .pin_reset_n(pin_reset_n),
  .pin_test(pin_test), .pin_vpp_high(pin_vpp_high), .prog_addr(prog_addr), .stack_ptr(stack_ptr),
  .class_sel(class_sel), .op_mode(op_mode), .irq_mode(irq_mode), .busy(busy));

// ---- tb/cseq_pins_model.sv ----
// Purpose: board side model of the reset, test and supply pins
// Assumes: pins change just after a rising hclk edge
// Notes: the bad code raises test so that commands are blocked
`timescale 1ns/1ps
module cseq_pins_model (
  input wire logic hclk,
  input wire cseq_pkg::cseq_mode_type want,
  output logic pin_reset_n,
  output logic pin_test,
  output logic pin_vpp_high
);
  import cseq_pkg::*;
  ////////////////////////////////////////
  // one pin pattern for each operating mode
  initial {pin_reset_n, pin_test, pin_vpp_high} = 3'b000;
  always @(posedge hclk)
  begin
    case (want)
      MODE_PROG: {pin_reset_n, pin_test, pin_vpp_high} <= 3'b001;
      MODE_WORK: {pin_reset_n, pin_test, pin_vpp_high} <= 3'b100;
      MODE_BAD: {pin_reset_n, pin_test, pin_vpp_high} <= 3'b110;
      default: {pin_reset_n, pin_test, pin_vpp_high} <= 3'b000;
    endcase
  end
endmodule

// ---- tb/cseq_top_tb_top.sv ----
// Purpose: self-checking bench of the core sequencer
// Assumes: zero wait state slave, commands over the register bus
// Notes: expectations come from bench variables, never from the design
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cseq_top_tb_top;
  import cseq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, irq_mode, busy, pin_reset_n, pin_test, pin_vpp_high;
  logic [31:0] hrdata, rd;
  logic [12:0] prog_addr, pc, tgt, ret_pc;
  logic [7:0] stack_ptr, a, b;
  logic [4:0] class_sel, cls;
  logic [1:0] op_mode;
  logic [2:0] fn, fi;
  logic [3:0] ops [6] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  int lens [6] = '{8, 8, 8, 6, 26, 8};
  // one-hot decoder enable per op: control, load, arith, fuzzy, arith, control
  logic [4:0] cls_exp [6] = '{5'h08, 5'h01, 5'h02, 5'h10, 5'h02, 5'h08};
  cseq_mode_type modes [3] = '{MODE_PROG, MODE_RESET, MODE_WORK};
  cseq_mode_type want = MODE_WORK;
  int n_errors = 0;
  int n_compared = 0;
  int n_cyc;
  integer seed = 32'h90e1;
  ////////////////////////////////////////
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  cseq_pins_model u_pins (.hclk(hclk), .want(want), .pin_reset_n(pin_reset_n), .pin_test(pin_test),
    .pin_vpp_high(pin_vpp_high));
  cseq_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pin_reset_n(pin_reset_n), .pin_test(pin_test),
    .pin_vpp_high(pin_vpp_high), .prog_addr(prog_addr), .stack_ptr(stack_ptr),
    .class_sel(class_sel), .op_mode(op_mode), .irq_mode(irq_mode), .busy(busy));
  // flags as {sign, zero, carry}
  function automatic logic [2:0] add_f(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    return {1'b0, s[7:0] == 8'h0, s[8]};
  endfunction
  function automatic logic [2:0] sub_f(input logic [7:0] x, input logic [7:0] y);
    return {x < y, x == y, 1'b0};
  endfunction
  // single transfer: address phase, then data phase, both held until ready
  task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK({hreadyout, hresp}, 2'b10)
  endtask
  task automatic rd_is(input logic [11:0] ofs, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, ofs, 32'h0);
    `CHK(rd & m, e)
  endtask
  // the busy count is bounded so a stuck sequencer cannot hang the run
  task automatic run(input logic [3:0] op, input logic [12:0] opnd, input logic [7:0] x, input logic [7:0] y);
    bus(1'b1, OFS_OPND, {19'h0, opnd});
    bus(1'b1, OFS_ARG, {16'h0, y, x});
    bus(1'b1, OFS_CMD, {28'h0, op});
    n_cyc = 0;
    while (n_cyc < 40)
    begin
      @(negedge hclk);
      if (n_cyc == 0) cls = class_sel;
      if (busy !== 1'b1) break;
      n_cyc++;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge hclk);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_is(OFS_PC, 32'h1fff, 32'h0);
    rd_is(OFS_SP, 32'hff, 32'hff);
    rd_is(12'h020, 32'hffffffff, 32'h0);
    pc = 13'h0;
    $display("test reset done");
    foreach (ops[i])
    begin
      run(ops[i], 13'h0, 8'h0, 8'h0);
      pc = pc + 13'h1;
      `CHK(n_cyc, lens[i])
      `CHK(cls, cls_exp[i])
      rd_is(OFS_PC, 32'h1fff, {19'h0, pc});
    end
    $display("test classes done");
    // corner cases first, then random operands
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      b = (i < 2) ? 8'h01 : 8'($random(seed));
      run((i % 2) ? 4'h7 : 4'h6, 13'h0, a, b);
      fn = (i % 2) ? sub_f(a, b) : add_f(a, b);
      pc = pc + 13'h1;
      rd_is(OFS_FLAGS, 32'h7, {29'h0, fn});
    end
    $display("test arith done");
    // call, change flags inside, take an interrupt, return three times
    tgt = 13'($random(seed));
    ret_pc = pc;
    run(4'h2, tgt, 8'h0, 8'h0);
    rd_is(OFS_SP, 32'hff, 32'hfd);
    rd_is(OFS_PC, 32'h1fff, {19'h0, tgt});
    run(4'h6, 13'h0, 8'hff, 8'h01);
    fn = 3'b011;
    run(4'h3, 13'h0abc, 8'h0, 8'h0);
    `CHK(irq_mode, 1'b1)
    rd_is(OFS_SP, 32'hff, 32'hfb);
    run(4'h6, 13'h0, 8'h80, 8'h80);
    fi = add_f(8'h80, 8'h80);
    rd_is(OFS_FLAGS, 32'h77, {25'h0, fi, 1'b0, fn});
    // nested level: change the interrupt set, its return must bring the saved set back
    run(4'h3, 13'h0123, 8'h0, 8'h0);
    run(4'h7, 13'h0, 8'h00, 8'h01);
    run(4'h5, 13'h0, 8'h0, 8'h0);
    rd_is(OFS_FLAGS, 32'h77, {25'h0, fi, 1'b0, fn});
    run(4'h5, 13'h0, 8'h0, 8'h0);
    `CHK(irq_mode, 1'b0)
    rd_is(OFS_PC, 32'h1fff, {19'h0, tgt + 13'h1});
    rd_is(OFS_FLAGS, 32'h77, {25'h0, fi, 1'b0, fn});
    rd_is(OFS_SP, 32'hff, 32'hfd);
    run(4'h4, 13'h0, 8'h0, 8'h0);
    rd_is(OFS_PC, 32'h1fff, {19'h0, ret_pc});
    rd_is(OFS_FLAGS, 32'h7, {29'h0, fn});
    rd_is(OFS_SP, 32'hff, 32'hff);
    $display("test stack done");
    foreach (modes[i])
    begin
      @(posedge hclk);
      want <= modes[i];
      repeat (4) @(posedge hclk);
      rd_is(OFS_STAT, 32'h60, {25'h0, modes[i], 5'h0});
    end
    rd_is(OFS_PC, 32'h1fff, 32'h0);
    $display("test modes done");
    wrap_up();
  end
endmodule
